// *** inc/bus_area_pkg.sv ***
package bus_area_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	// Two registers, one aligned word each, low 16 bits used.
	localparam logic [7:0] BUS_CONTROL_ONE_OFF = 8'h00;
	localparam logic [7:0] BUS_CONTROL_TWO_OFF = 8'h04;

	// ------------------------------------------------------------------
	// Field positions of the first bus control register
	// ------------------------------------------------------------------
	localparam int ARB_SLAVE_BIT = 15;
	localparam int ENDIAN_BIT = 12;
	localparam int BURST_ROM_BIT = 11;
	localparam int PART_SHARE_BIT = 10;
	localparam int AREA23_LW_LSB = 8;
	localparam int AREA1_LW_LSB = 6;
	localparam int AREA0_LW_LSB = 4;
	localparam int MEM_TYPE_LSB = 0;

	// ------------------------------------------------------------------
	// Field positions of the second bus control register
	// ------------------------------------------------------------------
	localparam int AREA3_WIDTH_LSB = 6;
	localparam int AREA2_WIDTH_LSB = 4;
	localparam int AREA1_WIDTH_LSB = 2;

	// ------------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------------
	localparam logic [1:0] AREA23_LW_RESET = 2'h3;
	localparam logic [1:0] AREA1_LW_RESET = 2'h3;
	localparam logic [1:0] AREA0_LW_RESET = 2'h0;
	localparam logic [2:0] MEM_TYPE_RESET = 3'h0;
	localparam logic [1:0] WIDTH_RESET = 2'h3;

	// ------------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------------
	localparam logic [1:0] WAIT_CODE_LONG = 2'h3;
	localparam logic [2:0] LONG_WAIT_BASE = 3'h3;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;
	localparam logic [1:0] WIDTH_LONG = 2'h3;

	// Memory type of areas 2 and 3.
	typedef enum logic [2:0] {
		MT_ORDINARY = 3'h0,
		MT_A3_SDRAM = 3'h1,
		MT_A3_DRAM = 3'h2,
		MT_A3_PSRAM = 3'h3,
		MT_A2_SDRAM = 3'h4,
		MT_BOTH_SDRAM = 3'h5
	} mem_type_t;

endpackage

// *** core/area_wait_sel.sv ***
// Resolves the wait count and wait-input enable of one area from its
// wait control code and its long-wait field.
module area_wait_sel
	import bus_area_pkg::*;
(
	// Settings
	input wire logic [1:0] wait_code,
	input wire logic [1:0] long_wait,
	input wire logic basic_if,
	// Result
	output logic [2:0] wait_count,
	output logic ext_wait_en
);
	import bus_area_pkg::*;

	// Long wait adds the field to a base of three waits; other codes count directly.
	always_comb begin
		if (basic_if && wait_code == WAIT_CODE_LONG) begin
			wait_count = LONG_WAIT_BASE + {1'b0, long_wait};
		end else begin
			wait_count = {1'b0, wait_code};
		end
		ext_wait_en = (wait_code != 2'h0);
	end

endmodule

// *** core/bus_area_config_regs.sv ***
// Behaviour
// - Burst ROM bit runs area 0 as burst.
// - Partial share: only area 2 requests bus.
// - Partial share disables address monitoring.
// - Long wait applies only basic interface, code 11.
// - Area 2/3 long wait 3..6, reset 6.
// - Area 1 long wait 3..6, reset 6.
// - Area 0 long wait 3..6, reset 3.
// - Memory type code selects area 2/3 memories.
// - Area 3 width 8/16/32, reset 32.
// - Area 2 width 8/16/32, reset 32.
// - Area 1 width byte/word/long, reset long.
// - Reserved bits read zero, writes ignored.
// - Area 0 width comes from mode pins.
// - Arbitration bit reads mode pin, 1 slave.
// - Wait code 11 selects long-wait count.
module bus_area_config_regs
	import bus_area_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Mode pins
	input wire logic MODE_SLAVE,
	input wire logic [1:0] MODE_AREA0_WIDTH,
	// Bus controller side
	input wire logic BUS_CYCLE_START,
	input wire logic [1:0] AREA_SEL,
	input wire logic [7:0] WAIT_CODES,
	// Resolved settings for the cycle now starting
	output logic AREA0_BURST_ROM,
	output logic AREA2_LITTLE_ENDIAN,
	output logic BUS_REQ_NEEDED,
	output logic ADDR_MONITOR_EN,
	output logic [2:0] MEM_TYPE,
	output logic [1:0] CYCLE_WIDTH,
	output logic [2:0] CYCLE_WAITS,
	output logic CYCLE_EXT_WAIT_EN
);
	import bus_area_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic little_endian;
		logic area0_burst_rom_en;
		logic partial_share_en;
		logic [1:0] area23_long_wait;
		logic [1:0] area1_long_wait;
		logic [1:0] area0_long_wait;
		logic [2:0] mem_type_sel;
		logic [1:0] area3_width;
		logic [1:0] area2_width;
		logic [1:0] area1_width;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic out_burst;
		logic out_endian;
		logic out_req;
		logic out_mon;
		logic [2:0] out_mem;
		logic [1:0] out_width;
		logic [2:0] out_waits;
		logic out_extw;
	} state_t;

	state_t state_r;
	state_t state_nxt;
	logic [15:0] reg_one;
	logic [15:0] reg_two;
	logic [2:0] area_waits [4];
	logic [3:0] area_extw;
	logic [3:0] area_basic;
	logic [1:0] area_long [4];
	logic access;
	logic mapped;

	// ------------------------------------------------------------------
	// Read views
	// ------------------------------------------------------------------
	// Reserved bits are constant zero, so a stray write can never set them.
	always_comb begin
		reg_one = 16'h0000;
		reg_one[ARB_SLAVE_BIT] = MODE_SLAVE;
		reg_one[ENDIAN_BIT] = state_r.little_endian;
		reg_one[BURST_ROM_BIT] = state_r.area0_burst_rom_en;
		reg_one[PART_SHARE_BIT] = state_r.partial_share_en;
		reg_one[AREA23_LW_LSB +: 2] = state_r.area23_long_wait;
		reg_one[AREA1_LW_LSB +: 2] = state_r.area1_long_wait;
		reg_one[AREA0_LW_LSB +: 2] = state_r.area0_long_wait;
		reg_one[MEM_TYPE_LSB +: 3] = state_r.mem_type_sel;
		reg_two = 16'h0000;
		reg_two[AREA3_WIDTH_LSB +: 2] = state_r.area3_width;
		reg_two[AREA2_WIDTH_LSB +: 2] = state_r.area2_width;
		reg_two[AREA1_WIDTH_LSB +: 2] = state_r.area1_width;
	end

	// ------------------------------------------------------------------
	// Per-area wait resolution
	// ------------------------------------------------------------------
	// Area 0 and 1 are always basic; area 2 and 3 only as ordinary space.
	assign area_basic[0] = 1'b1;
	assign area_basic[1] = 1'b1;
	assign area_basic[2] = !(state_r.mem_type_sel inside {MT_A2_SDRAM, MT_BOTH_SDRAM});
	assign area_basic[3] = (state_r.mem_type_sel == MT_ORDINARY)
		|| (state_r.mem_type_sel == MT_A2_SDRAM);
	assign area_long[0] = state_r.area0_long_wait;
	assign area_long[1] = state_r.area1_long_wait;
	assign area_long[2] = state_r.area23_long_wait;
	assign area_long[3] = state_r.area23_long_wait;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_area
			area_wait_sel u_sel (
				.wait_code(WAIT_CODES[2 * gi +: 2]),
				.long_wait(area_long[gi]),
				.basic_if(area_basic[gi]),
				.wait_count(area_waits[gi]),
				.ext_wait_en(area_extw[gi])
			);
		end
	endgenerate

	assign access = PSEL && PENABLE;
	assign mapped = (PADDR == BUS_CONTROL_ONE_OFF) || (PADDR == BUS_CONTROL_TWO_OFF);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// The slave answers in the second access cycle; ready is a registered
	// pulse, so every access takes exactly one wait in the access phase.
	always_comb begin
		state_nxt = state_r;
		state_nxt.ready = 1'b0;
		state_nxt.slverr = 1'b0;
		if (access && !state_r.ready) begin
			state_nxt.ready = 1'b1;
			state_nxt.slverr = !mapped;
			state_nxt.rdata = 32'h0000_0000;
			if (!PWRITE && PADDR == BUS_CONTROL_ONE_OFF) begin
				state_nxt.rdata = {16'h0000, reg_one};
			end
			if (!PWRITE && PADDR == BUS_CONTROL_TWO_OFF) begin
				state_nxt.rdata = {16'h0000, reg_two};
			end
		end
		// Writes land when the access completes.
		if (access && state_r.ready && PWRITE && PADDR == BUS_CONTROL_ONE_OFF) begin
			if (PSTRB[1]) begin
				state_nxt.little_endian = PWDATA[ENDIAN_BIT];
				state_nxt.area0_burst_rom_en = PWDATA[BURST_ROM_BIT];
				state_nxt.partial_share_en = PWDATA[PART_SHARE_BIT];
				state_nxt.area23_long_wait = PWDATA[AREA23_LW_LSB +: 2];
			end
			if (PSTRB[0]) begin
				state_nxt.area1_long_wait = PWDATA[AREA1_LW_LSB +: 2];
				state_nxt.area0_long_wait = PWDATA[AREA0_LW_LSB +: 2];
				// Forbidden memory codes are refused and the old setting kept.
				if (PWDATA[MEM_TYPE_LSB +: 3] <= 3'h5) begin
					state_nxt.mem_type_sel = PWDATA[MEM_TYPE_LSB +: 3];
				end
			end
		end
		// Width code 00 is forbidden; such a field write is ignored.
		if (access && state_r.ready && PWRITE && PADDR == BUS_CONTROL_TWO_OFF && PSTRB[0]) begin
			if (PWDATA[AREA3_WIDTH_LSB +: 2] != 2'h0) begin
				state_nxt.area3_width = PWDATA[AREA3_WIDTH_LSB +: 2];
			end
			if (PWDATA[AREA2_WIDTH_LSB +: 2] != 2'h0) begin
				state_nxt.area2_width = PWDATA[AREA2_WIDTH_LSB +: 2];
			end
			if (PWDATA[AREA1_WIDTH_LSB +: 2] != 2'h0) begin
				state_nxt.area1_width = PWDATA[AREA1_WIDTH_LSB +: 2];
			end
		end
		// Cycle settings are latched only at a cycle start, so a field
		// write never disturbs a cycle already on the bus.
		if (BUS_CYCLE_START) begin
			state_nxt.out_burst = state_r.area0_burst_rom_en && AREA_SEL == 2'h0;
			state_nxt.out_endian = state_r.little_endian && AREA_SEL == 2'h2;
			state_nxt.out_mon = !state_r.partial_share_en;
			state_nxt.out_req = !MODE_SLAVE
				&& (!state_r.partial_share_en || AREA_SEL == 2'h2);
			state_nxt.out_mem = state_r.mem_type_sel;
			state_nxt.out_waits = area_waits[AREA_SEL];
			state_nxt.out_extw = area_extw[AREA_SEL];
			unique case (AREA_SEL)
				2'h0: state_nxt.out_width = MODE_AREA0_WIDTH;
				2'h1: state_nxt.out_width = state_r.area1_width;
				2'h2: state_nxt.out_width = area_basic[2] ? state_r.area2_width
					: WIDTH_LONG;
				2'h3: state_nxt.out_width = (state_r.mem_type_sel == MT_ORDINARY
					|| state_r.mem_type_sel == MT_A2_SDRAM) ? state_r.area3_width
					: WIDTH_LONG;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_r <= '0;
			state_r.area23_long_wait <= AREA23_LW_RESET;
			state_r.area1_long_wait <= AREA1_LW_RESET;
			state_r.area0_long_wait <= AREA0_LW_RESET;
			state_r.mem_type_sel <= MEM_TYPE_RESET;
			state_r.area3_width <= WIDTH_RESET;
			state_r.area2_width <= WIDTH_RESET;
			state_r.area1_width <= WIDTH_RESET;
			state_r.out_mon <= 1'b1;
			state_r.out_width <= WIDTH_LONG;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign PRDATA = state_r.rdata;
	assign PREADY = state_r.ready;
	assign PSLVERR = state_r.slverr;
	assign AREA0_BURST_ROM = state_r.out_burst;
	assign AREA2_LITTLE_ENDIAN = state_r.out_endian;
	assign BUS_REQ_NEEDED = state_r.out_req;
	assign ADDR_MONITOR_EN = state_r.out_mon;
	assign MEM_TYPE = state_r.out_mem;
	assign CYCLE_WIDTH = state_r.out_width;
	assign CYCLE_WAITS = state_r.out_waits;
	assign CYCLE_EXT_WAIT_EN = state_r.out_extw;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_answer;
		PSEL && PENABLE ##1 PREADY;
	endsequence

	a_apb_ready_one: assert property (@(posedge CLK) disable iff (RESET)
		s_setup ##1 s_answer |=> !PREADY)
		else $error("ready lasted more than one cycle");
	a_reserved_two_zero: assert property (@(posedge CLK) disable iff (RESET)
		PREADY && !PSLVERR && $past(PADDR) == BUS_CONTROL_TWO_OFF && !$past(PWRITE)
		|-> PRDATA[31:8] == 24'h0 && PRDATA[1:0] == 2'h0)
		else $error("reserved bits read nonzero");
	a_arb_bit_pin: assert property (@(posedge CLK) disable iff (RESET)
		PREADY && $past(PADDR) == BUS_CONTROL_ONE_OFF && !$past(PWRITE)
		|-> PRDATA[ARB_SLAVE_BIT] == $past(MODE_SLAVE))
		else $error("arbitration bit does not follow pin");
	a_share_no_req: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && state_r.partial_share_en && AREA_SEL != 2'h2 |=> !BUS_REQ_NEEDED)
		else $error("bus requested outside area 2");
	a_share_mon_off: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && state_r.partial_share_en |=> !ADDR_MONITOR_EN)
		else $error("address monitor on in partial share");
	a_burst_area0: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h0 |=> AREA0_BURST_ROM == $past(state_r.area0_burst_rom_en))
		else $error("burst rom setting not applied");
	a_long_wait_a0: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h0 && WAIT_CODES[1:0] == 2'h3
		|=> CYCLE_WAITS == 3'h3 + $past(state_r.area0_long_wait))
		else $error("area 0 long wait wrong");
	a_long_wait_a1: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h1 && WAIT_CODES[3:2] == 2'h3
		|=> CYCLE_WAITS == 3'h3 + $past(state_r.area1_long_wait))
		else $error("area 1 long wait wrong");
	a_short_wait: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h1 && WAIT_CODES[3:2] != 2'h3
		|=> CYCLE_WAITS == {1'b0, $past(WAIT_CODES[3:2])})
		else $error("short wait wrong");
	a_area0_width_pin: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h0 |=> CYCLE_WIDTH == $past(MODE_AREA0_WIDTH))
		else $error("area 0 width not from pins");
	a_long_wait_a2: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h2 && WAIT_CODES[5:4] == 2'h3 && area_basic[2]
		|=> CYCLE_WAITS == 3'h3 + $past(state_r.area23_long_wait))
		else $error("area 2 long wait wrong");
	a_area1_width: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h1 |=> CYCLE_WIDTH == $past(state_r.area1_width))
		else $error("area 1 width not applied");
	a_long_ext_wait: assert property (@(posedge CLK) disable iff (RESET)
		BUS_CYCLE_START && AREA_SEL == 2'h1 && WAIT_CODES[3:2] == 2'h3 |=> CYCLE_EXT_WAIT_EN)
		else $error("external wait off with long wait");
	a_hold_mid_cycle: assert property (@(posedge CLK) disable iff (RESET)
		!BUS_CYCLE_START |=> $stable(CYCLE_WIDTH) && $stable(CYCLE_WAITS))
		else $error("settings changed mid cycle");

endmodule

// *** sim/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bus_area_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [3:0] PSTRB = 4'h0;
	logic PREADY, PSLVERR, MODE_SLAVE = 0, BUS_CYCLE_START = 0;
	logic [1:0] MODE_AREA0_WIDTH = 2'h1, AREA_SEL = 2'h0, CYCLE_WIDTH;
	logic [7:0] WAIT_CODES = 8'h00;
	logic AREA0_BURST_ROM, AREA2_LITTLE_ENDIAN, BUS_REQ_NEEDED, ADDR_MONITOR_EN;
	logic CYCLE_EXT_WAIT_EN;
	logic [2:0] MEM_TYPE, CYCLE_WAITS;
	int error_cnt = 0, n_compared = 0, cycles = 0;

	bus_area_config_regs i_bus_area_config_regs (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MODE_SLAVE(MODE_SLAVE),
		.MODE_AREA0_WIDTH(MODE_AREA0_WIDTH), .BUS_CYCLE_START(BUS_CYCLE_START),
		.AREA_SEL(AREA_SEL), .WAIT_CODES(WAIT_CODES), .AREA0_BURST_ROM(AREA0_BURST_ROM),
		.AREA2_LITTLE_ENDIAN(AREA2_LITTLE_ENDIAN), .BUS_REQ_NEEDED(BUS_REQ_NEEDED),
		.ADDR_MONITOR_EN(ADDR_MONITOR_EN), .MEM_TYPE(MEM_TYPE), .CYCLE_WIDTH(CYCLE_WIDTH),
		.CYCLE_WAITS(CYCLE_WAITS), .CYCLE_EXT_WAIT_EN(CYCLE_EXT_WAIT_EN));

	// 25 MHz clock.
	initial begin
		forever #20 CLK = ~CLK;
	end

	// A hang ends the run as a mismatch; the whole test needs far fewer cycles.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Register read data compare.
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Port output compare.
	task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: port %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request stands until PREADY is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= wr ? 4'hF : 4'h0;
		@(posedge CLK);
		PENABLE <= 1;
		// No fixed latency is assumed; only the bench timeout ends a hung wait.
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
	endtask

	// Read a mapped register and compare it with the expected word.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		cmp_reg(rd, exp | {MODE_SLAVE, 15'h0});
		cmp_out(err, 0);
	endtask

	// One bus-controller cycle start; outputs are settled by the falling edge after.
	task automatic cyc(input logic [1:0] a, input logic [7:0] c);
		@(posedge CLK);
		BUS_CYCLE_START <= 1;
		AREA_SEL <= a;
		WAIT_CODES <= c;
		@(posedge CLK);
		BUS_CYCLE_START <= 0;
		@(negedge CLK);
	endtask

	task automatic expect_cycle(input logic [1:0] w, input logic [2:0] n, input logic e);
		cmp_out(CYCLE_WIDTH, w);
		cmp_out(CYCLE_WAITS, n);
		cmp_out(CYCLE_EXT_WAIT_EN, e);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		cmp_out(ADDR_MONITOR_EN, 1);
		cmp_out(CYCLE_WIDTH, 3);
		rdchk(BUS_CONTROL_ONE_OFF, 32'h03C0);
		rdchk(BUS_CONTROL_TWO_OFF, 32'h00FC);
		// Only area 0 is used until both registers have been set up once.
		cyc(0, 8'h03);
		expect_cycle(MODE_AREA0_WIDTH, 3, 1);
		wr(BUS_CONTROL_ONE_OFF, 32'h03C0);
		wr(BUS_CONTROL_TWO_OFF, 32'h00FC);
		cyc(1, 8'h0C);
		expect_cycle(3, 6, 1);
		cyc(2, 8'h30);
		expect_cycle(3, 6, 1);
	endtask

	// Widths first, so the memory-type sweep sees byte width on ordinary areas.
	task automatic t_widths_mem();
		wr(BUS_CONTROL_TWO_OFF, 32'hFF58);
		rdchk(BUS_CONTROL_TWO_OFF, 32'h0058);
		cyc(1, 8'h00);
		expect_cycle(2, 0, 0);
		@(posedge CLK);
		MODE_AREA0_WIDTH <= 2'h2;
		cyc(0, 8'h00);
		expect_cycle(2, 0, 0);
		for (int m = 0; m < 6; m++) begin
			wr(BUS_CONTROL_ONE_OFF, 32'h0330 | m);
			rdchk(BUS_CONTROL_ONE_OFF, 32'h0330 | m);
			cyc(2, 8'h30);
			cmp_out(MEM_TYPE, m);
			expect_cycle((m >= 4) ? 3 : 1, (m >= 4) ? 3 : 6, 1);
			cyc(3, 8'hC0);
			expect_cycle((m == 0 || m == 4) ? 1 : 3, (m == 0 || m == 4) ? 6 : 3, 1);
		end
		wr(BUS_CONTROL_ONE_OFF, 32'h0336);
		rdchk(BUS_CONTROL_ONE_OFF, 32'h0335);
		wr(BUS_CONTROL_TWO_OFF, 32'hFFC3);
		rdchk(BUS_CONTROL_TWO_OFF, 32'h00D8);
	endtask

	task automatic t_long();
		logic [2:0] exp [4] = '{5, 4, 5, 5};
		wr(BUS_CONTROL_ONE_OFF, 32'h0260);
		for (int a = 0; a < 4; a++) begin
			cyc(a, 8'hFF);
			cmp_out(CYCLE_WAITS, exp[a]);
		end
		cyc(1, 8'h04);
		expect_cycle(2, 1, 1);
		wr(BUS_CONTROL_ONE_OFF, 32'h0261);
		cyc(3, 8'hFF);
		cmp_out(CYCLE_WAITS, 3);
	endtask

	task automatic t_share();
		wr(BUS_CONTROL_ONE_OFF, 32'h6338);
		rdchk(BUS_CONTROL_ONE_OFF, 32'h0330);
		cyc(1, 8'h00);
		cmp_out({BUS_REQ_NEEDED, ADDR_MONITOR_EN}, 3);
		wr(BUS_CONTROL_ONE_OFF, 32'h0730);
		cyc(1, 8'h00);
		cmp_out({BUS_REQ_NEEDED, ADDR_MONITOR_EN}, 0);
		cyc(2, 8'h00);
		cmp_out(BUS_REQ_NEEDED, 1);
		@(posedge CLK);
		MODE_SLAVE <= 1;
		rdchk(BUS_CONTROL_ONE_OFF, 32'h0730);
		cyc(2, 8'h00);
		cmp_out(BUS_REQ_NEEDED, 0);
		@(posedge CLK);
		MODE_SLAVE <= 0;
	endtask

	// A new setting must wait for the next cycle start before it shows.
	task automatic t_burst();
		cyc(0, 8'h00);
		cmp_out(AREA0_BURST_ROM, 0);
		wr(BUS_CONTROL_ONE_OFF, 32'h0B30);
		cmp_out(AREA0_BURST_ROM, 0);
		cyc(0, 8'h00);
		cmp_out(AREA0_BURST_ROM, 1);
		wr(BUS_CONTROL_ONE_OFF, 32'h1B30);
		cmp_out(AREA2_LITTLE_ENDIAN, 0);
		cyc(2, 8'h00);
		cmp_out(AREA2_LITTLE_ENDIAN, 1);
	endtask

	task automatic t_unmapped();
		logic [31:0] rd;
		logic err;
		apb(1'b1, 8'h0C, 32'hFFFF, rd, err);
		cmp_out(err, 1);
		apb(1'b0, 8'h08, 32'h0, rd, err);
		cmp_out(err, 1);
		rdchk(BUS_CONTROL_TWO_OFF, 32'h00D8);
	endtask

	// Main sequence.
	initial begin
		repeat (3) @(posedge CLK);
		RESET <= 0;
		@(negedge CLK);
		t_reset();
		t_widths_mem();
		t_long();
		t_share();
		t_burst();
		t_unmapped();
		end_of_test();
	end
endmodule
